// [design/temp_sensor_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-wire bus target with pointer and result registers
// What this block does
// - eight-bit pointer held; only its two low bits pick the data register.
// - codes 0..3 select result, configuration, low limit, high limit.
// - pointer select bits reset to zero, so reads default to the result.
// - result holds latest conversion, 12 bits normal, 13 bits extended.
// - result read sends most significant byte first, then least.
// - controller may stop after the first byte; no error, no side effect.
// - temperature occupies the leading 12 or 13 bits, left-justified.
// - one step of the value is 0.0625 degrees.
// - negative temperatures are two's complement.
// - result reads zero after reset until the first conversion lands.
// - low byte bit 0 is 0 in normal, 1 in extended format.
// - unused result bits always read zero.
// - strap input picks one of four target addresses.
// - configuration format flag: 0 normal, 1 extended 13-bit formats.
// - normal format: byte one bits 11..4, byte two bits 3..0 then zeros.
// - general-call reset acts as power-up: registers reset, conversion restarts.
module temp_sensor_regs (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [1:0] address_strap_input,
  input wire logic conv_valid,
  input wire logic [12:0] conv_value,
  output logic conv_start,
  output logic extended_format_flag
);

  reg_link_if link ();

  tsens_pkg::tgt_state_t state_ff;
  logic scl_s1_ff, scl_s2_ff, scl_d_ff, sda_s1_ff, sda_s2_ff, sda_d_ff;
  logic [1:0] strap_s1_ff, strap_s2_ff;
  logic [7:0] sh_ff, tx_ff;
  logic [3:0] cnt_ff;
  logic [1:0] idx_ff;
  logic rw_ff, gc_ff, nack_ff, oe_n_ff;
  logic ptr_wr_ff, data_wr_ff, data_hi_ff, gc_reset_ff;
  logic [7:0] wdata_ff;
  logic scl_rise, scl_fall, start_cond, stop_cond, byte_done;
  logic [6:0] own_addr;
  logic addr_hit, gc_hit;

  // next byte index toward the bank, saturating on the last slot
  function automatic logic [1:0] idx_step(input logic [1:0] i);
    return (i == 2'h3) ? i : i + 2'h1;
  endfunction

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      strap_s1_ff <= 2'h0;
      strap_s2_ff <= 2'h0;
    end else begin
      scl_s1_ff <= scl;
      scl_s2_ff <= scl_s1_ff;
      scl_d_ff <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_d_ff <= sda_s2_ff;
      strap_s1_ff <= address_strap_input;
      strap_s2_ff <= strap_s1_ff;
    end
  end

  // ==========================================================
  // bus event decode
  assign scl_rise = scl_s2_ff & ~scl_d_ff;
  assign scl_fall = ~scl_s2_ff & scl_d_ff;
  assign start_cond = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
  assign stop_cond = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;
  assign byte_done = scl_fall & (cnt_ff == tsens_pkg::BITS_PER_BYTE);
  assign own_addr = {tsens_pkg::BASE_ADDR[6:2], strap_s2_ff};
  assign gc_hit = (sh_ff[7:1] == tsens_pkg::GC_ADDR) & ~sh_ff[0];
  assign addr_hit = (sh_ff[7:1] == own_addr) | gc_hit;

  // ==========================================================
  // register bank link
  assign link.ptr_wr = ptr_wr_ff;
  assign link.data_wr = data_wr_ff;
  assign link.data_hi = data_hi_ff;
  assign link.wdata = wdata_ff;
  assign link.gc_reset = gc_reset_ff;
  assign link.rd_hi = (idx_ff == 2'h0);

  sensor_reg_bank u_bank (
    .mclk(mclk),
    .rst_n(rst_n),
    .conv_valid(conv_valid),
    .conv_value(conv_value),
    .conv_start(conv_start),
    .extended_format_flag(extended_format_flag),
    .link(link)
  );

  // open-drain data pin: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_ff;

  // one-cycle strobes toward the bank on each received pointer, data or reset command byte
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_wr_ff <= 1'b0;
      data_wr_ff <= 1'b0;
      data_hi_ff <= 1'b0;
      gc_reset_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      ptr_wr_ff <= (state_ff == tsens_pkg::ST_RX) & byte_done & ~gc_ff & (idx_ff == 2'h0);
      data_wr_ff <= (state_ff == tsens_pkg::ST_RX) & byte_done & ~gc_ff & (idx_ff != 2'h0);
      data_hi_ff <= (idx_ff == 2'h1);
      gc_reset_ff <= (state_ff == tsens_pkg::ST_RX) & byte_done & gc_ff
                     & (sh_ff == tsens_pkg::GC_RESET_CMD);
      wdata_ff <= sh_ff;
    end
  end

  // ==========================================================
  // target state machine: sample on rising clock, drive on falling clock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= tsens_pkg::ST_IDLE;
      sh_ff <= 8'h00;
      tx_ff <= 8'h00;
      cnt_ff <= 4'h0;
      idx_ff <= 2'h0;
      rw_ff <= 1'b0;
      gc_ff <= 1'b0;
      nack_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end else if (start_cond) begin
      state_ff <= tsens_pkg::ST_ADDR;
      cnt_ff <= 4'h0;
      idx_ff <= 2'h0;
      oe_n_ff <= 1'b1;
    end else if (stop_cond) begin
      state_ff <= tsens_pkg::ST_IDLE;
      oe_n_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        tsens_pkg::ST_IDLE: begin
          oe_n_ff <= 1'b1;
        end
        tsens_pkg::ST_ADDR, tsens_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_ff <= {sh_ff[6:0], sda_s2_ff};
            cnt_ff <= cnt_ff + 4'h1;
          end else if (byte_done) begin
            cnt_ff <= 4'h0;
            if (state_ff == tsens_pkg::ST_ADDR) begin
              rw_ff <= sh_ff[0];
              gc_ff <= gc_hit;
              state_ff <= addr_hit ? tsens_pkg::ST_AACK : tsens_pkg::ST_IDLE;
              oe_n_ff <= ~addr_hit;
            end else begin
              // stray pointer bits are stored as sent; selection ignores them
              state_ff <= tsens_pkg::ST_WACK;
              oe_n_ff <= 1'b0;
              idx_ff <= idx_step(idx_ff);
            end
          end
        end
        tsens_pkg::ST_AACK, tsens_pkg::ST_WACK: begin
          if (scl_fall) begin
            cnt_ff <= 4'h0;
            if ((state_ff == tsens_pkg::ST_AACK) & rw_ff) begin
              state_ff <= tsens_pkg::ST_TX;
              oe_n_ff <= link.rd_byte[7];
              tx_ff <= {link.rd_byte[6:0], 1'b0};
            end else begin
              state_ff <= tsens_pkg::ST_RX;
              oe_n_ff <= 1'b1;
            end
          end
        end
        tsens_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_ff == 4'h7) begin
              state_ff <= tsens_pkg::ST_MACK;
              oe_n_ff <= 1'b1;
              cnt_ff <= 4'h0;
              idx_ff <= idx_step(idx_ff);
            end else begin
              oe_n_ff <= tx_ff[7];
              tx_ff <= {tx_ff[6:0], 1'b0};
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
        end
        tsens_pkg::ST_MACK: begin
          if (scl_rise) begin
            nack_ff <= sda_s2_ff;
          end else if (scl_fall) begin
            // a not-acknowledge ends the read quietly, even after one byte
            if (nack_ff) begin
              state_ff <= tsens_pkg::ST_IDLE;
            end else begin
              state_ff <= tsens_pkg::ST_TX;
              oe_n_ff <= link.rd_byte[7];
              tx_ff <= {link.rd_byte[6:0], 1'b0};
            end
          end
        end
        default: begin
          state_ff <= tsens_pkg::ST_IDLE;
          oe_n_ff <= 1'b1;
        end
      endcase
    end
  end

endmodule // temp_sensor_regs
`default_nettype wire

// [design/tsens_pkg.sv]
// ==========================================================
// shared constants of the temperature sensor register block
package tsens_pkg;

  // pointer codes
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CFG = 2'h1;
  localparam logic [1:0] PTR_LOW = 2'h2;
  localparam logic [1:0] PTR_HIGH = 2'h3;

  // reset values
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h60a0;
  localparam logic [15:0] LOW_RESET = 16'h0000;
  localparam logic [15:0] HIGH_RESET = 16'h0000;

  // configuration word: writable bits, fixed-one bits, field positions
  localparam logic [15:0] CFG_WR_MASK = 16'hffd0;
  localparam logic [15:0] CFG_FIXED_ONE = 16'h0020;
  localparam int EM_POS = 4;
  localparam int FMT_POS = 0;

  // bus addressing
  localparam logic [6:0] BASE_ADDR = 7'h48; // arbitrary, low two bits from strap
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // one-hot target states
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_AACK = 7'b0000100,
    ST_RX = 7'b0001000,
    ST_WACK = 7'b0010000,
    ST_TX = 7'b0100000,
    ST_MACK = 7'b1000000
  } tgt_state_t;

endpackage

// [design/reg_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bus target to register bank link
interface reg_link_if;
  logic ptr_wr;
  logic data_wr;
  logic data_hi;
  logic [7:0] wdata;
  logic gc_reset;
  logic rd_hi;
  logic [7:0] rd_byte;

  modport target (output ptr_wr, output data_wr, output data_hi, output wdata,
    output gc_reset, output rd_hi, input rd_byte);
  modport bank (input ptr_wr, input data_wr, input data_hi, input wdata,
    input gc_reset, input rd_hi, output rd_byte);
endinterface
`default_nettype wire

// [design/sensor_reg_bank.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// pointer, result, configuration and limit registers
module sensor_reg_bank (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic conv_valid,
  input wire logic [12:0] conv_value,
  output logic conv_start,
  output logic extended_format_flag,
  reg_link_if.bank link
);

  logic [7:0] ptr_ff;
  logic [15:0] temp_ff, cfg_ff, low_ff, high_ff;
  logic start_ff, boot_ff;
  logic [1:0] sel;
  logic em;
  logic [15:0] nxt_temp, rd_word, wr_word, cur_word;

  // only the two low pointer bits select a register
  assign sel = ptr_ff[1:0];
  assign em = cfg_ff[tsens_pkg::EM_POS];
  // normal: value left-justified, zeros below; extended: 13 bits then format flag
  assign nxt_temp = em ? {conv_value, 2'h0, 1'h1}
                       : {conv_value[11:0], 4'h0};
  // read mux; result is read-only
  assign rd_word = (sel == tsens_pkg::PTR_TEMP) ? temp_ff :
                   (sel == tsens_pkg::PTR_CFG) ? cfg_ff :
                   (sel == tsens_pkg::PTR_LOW) ? low_ff : high_ff;
  assign link.rd_byte = link.rd_hi ? rd_word[15:8] : rd_word[7:0];
  assign cur_word = (sel == tsens_pkg::PTR_CFG) ? cfg_ff :
                    (sel == tsens_pkg::PTR_LOW) ? low_ff : high_ff;
  assign wr_word = link.data_hi ? {link.wdata, cur_word[7:0]} : {cur_word[15:8], link.wdata};
  assign conv_start = start_ff;
  assign extended_format_flag = em;

  // pointer persists between transactions
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= tsens_pkg::PTR_RESET;
    end else if (link.gc_reset) begin
      ptr_ff <= tsens_pkg::PTR_RESET;
    end else if (link.ptr_wr) begin
      ptr_ff <= link.wdata;
    end
  end

  // latest completed conversion, zero until the first one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      temp_ff <= tsens_pkg::TEMP_RESET;
    end else if (link.gc_reset) begin
      temp_ff <= tsens_pkg::TEMP_RESET;
    end else if (conv_valid) begin
      temp_ff <= nxt_temp;
    end
  end

  // writable registers, byte by byte, result never written
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= tsens_pkg::CFG_RESET;
      low_ff <= tsens_pkg::LOW_RESET;
      high_ff <= tsens_pkg::HIGH_RESET;
    end else if (link.gc_reset) begin
      cfg_ff <= tsens_pkg::CFG_RESET;
      low_ff <= tsens_pkg::LOW_RESET;
      high_ff <= tsens_pkg::HIGH_RESET;
    end else if (link.data_wr) begin
      if (sel == tsens_pkg::PTR_CFG) begin
        cfg_ff <= (wr_word & tsens_pkg::CFG_WR_MASK) | tsens_pkg::CFG_FIXED_ONE;
      end
      if (sel == tsens_pkg::PTR_LOW) begin
        low_ff <= wr_word;
      end
      if (sel == tsens_pkg::PTR_HIGH) begin
        high_ff <= wr_word;
      end
      // PTR_TEMP: write dropped
    end
  end

  // conversion start pulse after reset release and on general-call reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_ff <= 1'b1;
      start_ff <= 1'b0;
    end else begin
      boot_ff <= 1'b0;
      start_ff <= boot_ff | link.gc_reset;
    end
  end

endmodule // sensor_reg_bank
`default_nettype wire

// [test/i2c_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bus controller model: link clock runs only inside frames
module i2c_host_model (
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  // released pins float to the pull-up level
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // start or repeated start, leaves the clock low
  task automatic start();
    #80 sda_drv = 1'b1;
    #80 scl = 1'b1;
    #80 sda_drv = 1'b0;
    #80 scl = 1'b0;
  endtask
  // stop, then bus free time
  task automatic stop();
    #80 sda_drv = 1'b0;
    #80 scl = 1'b1;
    #80 sda_drv = 1'b1;
    #80;
  endtask
  // one bit: data set mid-low, sampled mid-high
  task automatic bitx(input logic b, output logic r);
    #80 sda_drv = b;
    #80 scl = 1'b1;
    #80 r = sda;
    #80 scl = 1'b0;
  endtask
  // eight bits then the acknowledge slot; m = 1 ends a read
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
    output logic a);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(m, a);
  endtask
endmodule // i2c_host_model
`default_nettype wire

// [test/temp_sensor_regs_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checks of the sensor register block
module temp_sensor_regs_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic conv_start,
  input wire logic extended_format_flag
);
  logic [7:0] hi_cnt_ff;
  logic [7:0] nxt_hi_cnt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // cycles the link clock has stayed high, saturating
  assign nxt_hi_cnt = !scl ? 8'h00 : (hi_cnt_ff == 8'hff) ? hi_cnt_ff : hi_cnt_ff + 8'h01;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_ff <= 8'h00;
    end else begin
      hi_cnt_ff <= nxt_hi_cnt;
    end
  end
  a_boot_quiet: assert property ($rose(rst_n) |-> sda_oe_n [*3])
    else $error("data line driven right after reset");
  a_boot_start: assert property ($rose(rst_n) |-> ##[1:3] conv_start)
    else $error("no conversion start after reset");
  a_start_pulse: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_start_clears: assert property (conv_start |-> !extended_format_flag)
    else $error("format flag not reset at restart");
  a_flag_boot: assert property ($rose(rst_n) |-> !extended_format_flag)
    else $error("format flag set out of reset");
  a_drive_low: assert property (!sda_oe_n |-> !sda_out)
    else $error("data line driven high");
  a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !$past(scl))
    else $error("data line changed while clock high");
  a_idle_release: assert property (hi_cnt_ff > 8'h0a |-> sda_oe_n)
    else $error("data line held on an idle bus");
endmodule // temp_sensor_regs_asserts
bind temp_sensor_regs temp_sensor_regs_asserts chk (.mclk(mclk), .rst_n(rst_n), .scl(scl),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_start(conv_start),
  .extended_format_flag(extended_format_flag));
`default_nettype wire

// [test/tb_temp_sensor_regs.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench of the sensor register block
module tb_temp_sensor_regs;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic conv_valid = 1'b0;
  logic [12:0] conv_value = 13'h0000;
  logic [1:0] strap;
  logic scl, h_sda, sda, sda_out, sda_oe_n, conv_start, ext_flag, ext;
  logic [6:0] adr;
  logic [7:0] got;
  logic [7:0] exp_q[$];
  int num_errors = 0;
  int n_tests = 0;
  event rd_ev;
  always #20 mclk = ~mclk;
  // open-drain wire with pull-up: low when either party pulls
  assign sda = h_sda & (sda_oe_n | sda_out);
  i2c_host_model host (.scl(scl), .sda_drv(h_sda), .sda(sda));
  temp_sensor_regs uut (.mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_strap_input(strap),
    .conv_valid(conv_valid), .conv_value(conv_value), .conv_start(conv_start),
    .extended_format_flag(ext_flag));
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // monitor: each observed value meets the oldest note
  always @(rd_ev) begin
    chk(exp_q.pop_front(), got);
  end
  task automatic obs(input logic [7:0] e, input logic [7:0] g);
    exp_q.push_back(e);
    got = g;
    ->rd_ev;
  endtask
  task automatic wr(input logic [7:0] d, input logic e);
    logic [7:0] q;
    logic a;
    host.xfer(d, 1'b1, q, a);
    obs({7'h00, e}, {7'h00, a});
  endtask
  task automatic rd(input logic m, input logic [7:0] e);
    logic [7:0] q;
    logic a;
    host.xfer(8'hff, m, q, a);
    obs(e, q);
  endtask
  task automatic put(input logic [1:0] p, input logic [15:0] w, input bit n);
    host.start();
    wr({adr, 1'b0}, 1'b0);
    wr({6'h00, p}, 1'b0);
    if (n) wr(w[15:8], 1'b0);
    if (n) wr(w[7:0], 1'b0);
    host.stop();
  endtask
  task automatic get(input logic [15:0] e);
    host.start();
    wr({adr, 1'b1}, 1'b0);
    rd(1'b0, e[15:8]);
    rd(1'b1, e[7:0]);
    host.stop();
  endtask
  // general call with one command byte, both bytes acknowledged
  task automatic gcall(input logic [7:0] c);
    host.start();
    wr({tsens_pkg::GC_ADDR, 1'b0}, 1'b0);
    wr(c, 1'b0);
    host.stop();
  endtask
  task automatic conv(input logic [12:0] v);
    @(posedge mclk);
    #1;
    conv_valid = 1'b1;
    conv_value = v;
    @(posedge mclk);
    #1;
    conv_valid = 1'b0;
  endtask
  function automatic logic [15:0] res(input logic [12:0] v);
    return ext ? {v, 2'h0, 1'b1} : {v[11:0], 4'h0};
  endfunction
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #2000000;
    num_errors++;
    summarize();
  end
  // main sequence
  initial begin
    logic [12:0] v;
    logic [15:0] w;
    ext = 1'b0;
    strap = 2'($urandom(32'h06b5dde6));
    adr = {tsens_pkg::BASE_ADDR[6:2], strap};
    repeat (20) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    get(16'h0000);
    $display("test reset read done");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 13'h0c90 : (i == 1) ? 13'h07ff : 13'($urandom);
      conv(v);
      get(res(v));
      get(res(v));
    end
    $display("test normal format done");
    w = res(v);
    host.start();
    wr({adr, 1'b1}, 1'b0);
    rd(1'b1, w[15:8]);
    host.stop();
    get(w);
    $display("test short read done");
    for (int p = 0; p < 4; p++) begin
      w = 16'($urandom);
      put(2'(p), w, 1'b1);
      if (p == 0) w = res(v);
      if (p == 1) ext = w[4];
      if (p == 1) w = (w & tsens_pkg::CFG_WR_MASK) | tsens_pkg::CFG_FIXED_ONE;
      get(w);
      obs({7'h00, ext}, {7'h00, ext_flag});
    end
    $display("test register access done");
    put(tsens_pkg::PTR_CFG, 16'h60b0, 1'b1);
    ext = 1'b1;
    obs({7'h00, ext}, {7'h00, ext_flag});
    v = 13'h0960;
    conv(v);
    put(tsens_pkg::PTR_TEMP, 16'h0000, 1'b0);
    get(res(v));
    $display("test extended format done");
    host.start();
    wr({adr ^ 7'h01, 1'b1}, 1'b1);
    host.stop();
    put(tsens_pkg::PTR_LOW, 16'h1234, 1'b1);
    // a general call with another command changes nothing
    gcall(8'h04);
    get(16'h1234);
    obs({7'h00, ext}, {7'h00, ext_flag});
    gcall(tsens_pkg::GC_RESET_CMD);
    obs(8'h00, {7'h00, ext_flag});
    get(16'h0000);
    put(tsens_pkg::PTR_CFG, 16'h0000, 1'b0);
    get(tsens_pkg::CFG_RESET);
    put(tsens_pkg::PTR_LOW, 16'h0000, 1'b0);
    get(tsens_pkg::LOW_RESET);
    $display("test general call done");
    summarize();
  end
endmodule // tb_temp_sensor_regs
`default_nettype wire
